// ---- logic/tlic_pkg.sv ----
package tlic_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_SRC = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int VEC_W = 16;
	localparam int IDX_W = 4;

	// ----------------------------------------------------------------
	// machine cycle timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int PHASES_PER_MCYCLE = 4;
	localparam logic [1:0] PHASE_TWO = 2'h1;
	localparam logic [1:0] PHASE_FOUR = 2'h3;
	localparam int CALL_MCYCLES = 4;
	localparam logic [4:0] CALL_CLKS =
		5'(CALL_MCYCLES * PHASES_PER_MCYCLE);

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h01;
	localparam logic [7:0] ADDR_BASIC_ENABLE = 8'h02;
	localparam logic [7:0] ADDR_EXTENDED_ENABLE = 8'h03;
	localparam logic [7:0] ADDR_BASIC_PRIORITY = 8'h04;
	localparam logic [7:0] ADDR_EXTENDED_PRIORITY = 8'h05;
	localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h06;
	localparam logic [7:0] ADDR_TIMER2_FLAGS = 8'h07;
	localparam logic [7:0] ADDR_DMA_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_DEBUG_FLAGS = 8'h09;
	localparam logic [7:0] ADDR_IN_SERVICE = 8'h0A;

	// ----------------------------------------------------------------
	// writable bit masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_TIMER_CONTROL = 8'hAF;
	localparam logic [7:0] MASK_WATCHDOG_CONTROL = 8'h18;
	localparam logic [7:0] MASK_BASIC_ENABLE = 8'hBF;
	localparam logic [7:0] MASK_EXTENDED_ENABLE = 8'h3F;
	localparam logic [7:0] MASK_BASIC_PRIORITY = 8'h3F;
	localparam logic [7:0] MASK_EXTENDED_PRIORITY = 8'h10;
	localparam logic [7:0] MASK_SERIAL_CONTROL = 8'h03;
	localparam logic [7:0] MASK_TIMER2_FLAGS = 8'hC0;
	localparam logic [7:0] MASK_DMA_FLAGS = 8'h3F;
	localparam logic [7:0] MASK_DEBUG_FLAGS = 8'h0F;
	localparam logic [7:0] RESET_VALUE = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_EXT0_TYPE = 0;
	localparam int BIT_EXT0_FLAG = 1;
	localparam int BIT_EXT1_TYPE = 2;
	localparam int BIT_EXT1_FLAG = 3;
	localparam int BIT_TIMER0_FLAG = 5;
	localparam int BIT_TIMER1_FLAG = 7;
	localparam int BIT_WATCHDOG_FLAG = 3;
	localparam int BIT_TOP_FLAG = 4;
	localparam int BIT_GLOBAL_ENABLE = 7;
	localparam int BIT_EN_WATCHDOG = 4;
	localparam int BIT_EN_TOP = 5;
	localparam int BIT_PRIO_WATCHDOG = 4;
	localparam int BIT_SERIAL_RX = 0;
	localparam int BIT_SERIAL_TX = 1;
	localparam int BIT_TIMER2_CAPTURE = 6;
	localparam int BIT_TIMER2_OVERFLOW = 7;

	// ----------------------------------------------------------------
	// sources in fixed order, highest first
	// ----------------------------------------------------------------
	localparam int SRC_TOP = 0;
	localparam int SRC_EXT0 = 1;
	localparam int SRC_TIMER0 = 2;
	localparam int SRC_EXT1 = 3;
	localparam int SRC_TIMER1 = 4;
	localparam int SRC_SERIAL = 5;
	localparam int SRC_TIMER2 = 6;
	localparam int SRC_DMA = 7;
	localparam int SRC_HW_BP = 8;
	localparam int SRC_TEST = 9;
	localparam int SRC_SW_BP = 10;
	localparam int SRC_WATCHDOG = 11;

	localparam logic [1:0] LEVEL_LOW = 2'h0;
	localparam logic [1:0] LEVEL_HIGH = 2'h1;
	localparam logic [1:0] LEVEL_TOP = 2'h2;

	localparam logic [VEC_W-1:0] VECTORS [NUM_SRC] = '{
		16'h0033, 16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
		16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h0063
	};

	function automatic logic [VEC_W-1:0] vector_of(
		input logic [IDX_W-1:0] idx
	);
		logic [VEC_W-1:0] v;
		v = VECTORS[0];
		for (int i = 0; i < NUM_SRC; i++) begin
			if (idx == IDX_W'(i)) begin
				v = VECTORS[i];
			end
		end
		return v;
	endfunction

endpackage

// ---- logic/tlic_resolver.sv ----
`timescale 1ns/1ps
`default_nettype none

module tlic_resolver (
	input wire logic [tlic_pkg::NUM_SRC-1:0] req_in,
	input wire logic [tlic_pkg::NUM_SRC-1:0] high_in,
	output logic valid_out,
	output logic [tlic_pkg::IDX_W-1:0] index_out,
	output logic [1:0] level_out
);
	import tlic_pkg::*;

	// ----------------------------------------------------------------
	// first set bit in fixed order
	// ----------------------------------------------------------------
	function automatic logic [IDX_W-1:0] first_of(
		input logic [NUM_SRC-1:0] v
	);
		logic [IDX_W-1:0] r;
		r = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = IDX_W'(i);
			end
		end
		return r;
	endfunction

	logic [NUM_SRC-1:0] high_req;

	always_comb begin
		high_req = req_in & high_in;
		high_req[SRC_TOP] = 1'b0;
		valid_out = |req_in;
		if (req_in[SRC_TOP]) begin
			index_out = IDX_W'(SRC_TOP);
			level_out = LEVEL_TOP;
		end else if (|high_req) begin
			index_out = first_of(high_req);
			level_out = LEVEL_HIGH;
		end else begin
			index_out = first_of(req_in);
			level_out = LEVEL_LOW;
		end
	end

endmodule

`default_nettype wire

// ---- logic/tlic_core.sv ----
// Behaviour
// - twelve sources, three levels, each with flag, vector and enable
// - external inputs edge or level triggered by type bit
// - edge-mode external flag cleared on service entry
// - level-mode external flag follows input, not cleared on service
// - timer 0/1 flags set on overflow, cleared on service
// - timer 2 request is OR of two flags, software clears
// - watchdog flag bit 3 set on timeout, enabled by bit 4
// - serial request is OR of receive and transmit flags
// - top flag bit 4 set by dedicated input, own enable
// - top enable independent of global enable
// - top source fixed at the top level alone
// - software writes set or clear flags and raise interrupts
// - individual enables plus global enable masking all but top
// - three levels, no preemption by lower level
// - fixed order within a level, top first, watchdog last
// - seven sources have a bit moving them to high level
// - flags sampled and resolved in phase two of each cycle
// - call only if level free, last cycle, no enable write
// - pending requests are not remembered, each poll fresh
// - call loads the source's fixed vector address
// - external inputs active high, rising edge or high level
// - return from irq ends the in-service level
// - call lasts four machine cycles
`timescale 1ns/1ps
`default_nettype none

module tlic_core (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [tlic_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [tlic_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [tlic_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic ext_irq_in_0,
	input wire logic ext_irq_in_1,
	input wire logic top_priority_irq_in,
	input wire logic timer0_overflow_in,
	input wire logic timer1_overflow_in,
	input wire logic timer2_overflow_in,
	input wire logic timer2_capture_reload_in,
	input wire logic serial_rx_done_in,
	input wire logic serial_tx_done_in,
	input wire logic [5:0] dma_event_in,
	input wire logic [1:0] hw_breakpoint_in,
	input wire logic test_port_event_in,
	input wire logic sw_breakpoint_in,
	input wire logic watchdog_timeout_in,
	input wire logic last_mcycle_in,
	input wire logic enable_write_in,
	input wire logic return_from_irq_in,
	output logic call_out,
	output logic [tlic_pkg::VEC_W-1:0] call_vector_out,
	output logic [1:0] call_level_out,
	output logic call_busy_out,
	output logic [2:0] in_service_out,
	output logic [1:0] machine_phase_out
);
	import tlic_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] timer_control_reg;
		logic [7:0] watchdog_control_reg;
		logic [7:0] basic_enable_reg;
		logic [7:0] extended_enable_reg;
		logic [7:0] basic_priority_reg;
		logic [7:0] extended_priority_reg;
		logic [7:0] serial_control_reg;
		logic [7:0] timer2_flags_reg;
		logic [7:0] dma_flags_reg;
		logic [7:0] debug_flags_reg;
		logic [1:0] phase;
		logic [4:0] busy;
		logic [2:0] in_service;
		logic [1:0] ext_prev;
		logic call;
		logic [VEC_W-1:0] vector;
		logic [1:0] level;
		logic [DATA_W-1:0] rdata;
	} tlic_state_t;

	tlic_state_t state_reg;
	tlic_state_t state_next;

	logic [NUM_SRC-1:0] req;
	logic [NUM_SRC-1:0] high;
	logic [NUM_SRC-1:0] enabled;
	logic res_valid;
	logic [IDX_W-1:0] res_index;
	logic [1:0] res_level;
	logic level_free;
	logic grant;
	logic ext0_edge_mode;
	logic ext1_edge_mode;

	// ----------------------------------------------------------------
	// request, enable and level vectors
	// ----------------------------------------------------------------
	always_comb begin
		ext0_edge_mode = state_reg.timer_control_reg[BIT_EXT0_TYPE];
		ext1_edge_mode = state_reg.timer_control_reg[BIT_EXT1_TYPE];
		req[SRC_TOP] = state_reg.watchdog_control_reg[BIT_TOP_FLAG];
		req[SRC_EXT0] = state_reg.timer_control_reg[BIT_EXT0_FLAG];
		req[SRC_TIMER0] = state_reg.timer_control_reg[BIT_TIMER0_FLAG];
		req[SRC_EXT1] = state_reg.timer_control_reg[BIT_EXT1_FLAG];
		req[SRC_TIMER1] = state_reg.timer_control_reg[BIT_TIMER1_FLAG];
		req[SRC_SERIAL] = |state_reg.serial_control_reg;
		req[SRC_TIMER2] = |state_reg.timer2_flags_reg;
		req[SRC_DMA] = |state_reg.dma_flags_reg;
		req[SRC_HW_BP] = |state_reg.debug_flags_reg[1:0];
		req[SRC_TEST] = state_reg.debug_flags_reg[2];
		req[SRC_SW_BP] = state_reg.debug_flags_reg[3];
		req[SRC_WATCHDOG] =
			state_reg.watchdog_control_reg[BIT_WATCHDOG_FLAG];
		// individual enables, global gate spares the top source
		enabled[SRC_TOP] =
			state_reg.extended_enable_reg[BIT_EN_TOP];
		enabled[6:1] = state_reg.basic_enable_reg[5:0]
			& {6{state_reg.basic_enable_reg[BIT_GLOBAL_ENABLE]}};
		enabled[11:7] = state_reg.extended_enable_reg[4:0]
			& {5{state_reg.basic_enable_reg[BIT_GLOBAL_ENABLE]}};
		high = '0;
		high[6:1] = state_reg.basic_priority_reg[5:0];
		high[SRC_WATCHDOG] =
			state_reg.extended_priority_reg[BIT_PRIO_WATCHDOG];
	end

	tlic_resolver u_resolver (
		.req_in(req & enabled),
		.high_in(high),
		.valid_out(res_valid),
		.index_out(res_index),
		.level_out(res_level)
	);

	// ----------------------------------------------------------------
	// grant conditions
	// ----------------------------------------------------------------
	always_comb begin
		level_free = 1'b1;
		for (int l = 0; l < 3; l++) begin
			if (state_reg.in_service[l] && 2'(l) >= res_level) begin
				level_free = 1'b0;
			end
		end
		// fresh evaluation each poll, nothing held over
		grant = (state_reg.phase == PHASE_TWO) && res_valid
			&& level_free && last_mcycle_in && !enable_write_in
			&& !return_from_irq_in && (state_reg.busy == 5'h00);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.call = 1'b0;
		state_next.rdata = '0;
		state_next.phase = state_reg.phase + 2'h1;
		if (state_reg.busy != 5'h00) begin
			state_next.busy = state_reg.busy - 5'h01;
		end

		// end of service
		if (return_from_irq_in) begin
			if (state_reg.in_service[2]) begin
				state_next.in_service[2] = 1'b0;
			end else if (state_reg.in_service[1]) begin
				state_next.in_service[1] = 1'b0;
			end else begin
				state_next.in_service[0] = 1'b0;
			end
		end

		// vectored call and service-entry clears
		if (grant) begin
			state_next.call = 1'b1;
			state_next.busy = CALL_CLKS;
			state_next.vector = vector_of(res_index);
			state_next.level = res_level;
			state_next.in_service[res_level] = 1'b1;
			if (res_index == IDX_W'(SRC_EXT0) && ext0_edge_mode) begin
				state_next.timer_control_reg[BIT_EXT0_FLAG] = 1'b0;
			end
			if (res_index == IDX_W'(SRC_EXT1) && ext1_edge_mode) begin
				state_next.timer_control_reg[BIT_EXT1_FLAG] = 1'b0;
			end
			if (res_index == IDX_W'(SRC_TIMER0)) begin
				state_next.timer_control_reg[BIT_TIMER0_FLAG] = 1'b0;
			end
			if (res_index == IDX_W'(SRC_TIMER1)) begin
				state_next.timer_control_reg[BIT_TIMER1_FLAG] = 1'b0;
			end
		end

		// software writes
		if (reg_write_in) begin
			case (reg_addr_in)
				ADDR_TIMER_CONTROL: begin
					state_next.timer_control_reg =
						reg_wdata_in & MASK_TIMER_CONTROL;
				end
				ADDR_WATCHDOG_CONTROL: begin
					state_next.watchdog_control_reg =
						reg_wdata_in & MASK_WATCHDOG_CONTROL;
				end
				ADDR_BASIC_ENABLE: begin
					state_next.basic_enable_reg =
						reg_wdata_in & MASK_BASIC_ENABLE;
				end
				ADDR_EXTENDED_ENABLE: begin
					state_next.extended_enable_reg =
						reg_wdata_in & MASK_EXTENDED_ENABLE;
				end
				ADDR_BASIC_PRIORITY: begin
					state_next.basic_priority_reg =
						reg_wdata_in & MASK_BASIC_PRIORITY;
				end
				ADDR_EXTENDED_PRIORITY: begin
					state_next.extended_priority_reg =
						reg_wdata_in & MASK_EXTENDED_PRIORITY;
				end
				ADDR_SERIAL_CONTROL: begin
					state_next.serial_control_reg =
						reg_wdata_in & MASK_SERIAL_CONTROL;
				end
				ADDR_TIMER2_FLAGS: begin
					state_next.timer2_flags_reg =
						reg_wdata_in & MASK_TIMER2_FLAGS;
				end
				ADDR_DMA_FLAGS: begin
					state_next.dma_flags_reg = reg_wdata_in & MASK_DMA_FLAGS;
				end
				ADDR_DEBUG_FLAGS: begin
					state_next.debug_flags_reg =
						reg_wdata_in & MASK_DEBUG_FLAGS;
				end
				default: begin
				end
			endcase
		end

		// external inputs sampled once per machine cycle
		if (state_reg.phase == PHASE_FOUR) begin
			state_next.ext_prev = {ext_irq_in_1, ext_irq_in_0};
			if (ext0_edge_mode) begin
				if (ext_irq_in_0 && !state_reg.ext_prev[0]) begin
					state_next.timer_control_reg[BIT_EXT0_FLAG] = 1'b1;
				end
			end else begin
				state_next.timer_control_reg[BIT_EXT0_FLAG] = ext_irq_in_0;
			end
			if (ext1_edge_mode) begin
				if (ext_irq_in_1 && !state_reg.ext_prev[1]) begin
					state_next.timer_control_reg[BIT_EXT1_FLAG] = 1'b1;
				end
			end else begin
				state_next.timer_control_reg[BIT_EXT1_FLAG] = ext_irq_in_1;
			end
		end

		// hardware events win over any clear
		if (timer0_overflow_in) begin
			state_next.timer_control_reg[BIT_TIMER0_FLAG] = 1'b1;
		end
		if (timer1_overflow_in) begin
			state_next.timer_control_reg[BIT_TIMER1_FLAG] = 1'b1;
		end
		if (top_priority_irq_in) begin
			state_next.watchdog_control_reg[BIT_TOP_FLAG] = 1'b1;
		end
		if (watchdog_timeout_in) begin
			state_next.watchdog_control_reg[BIT_WATCHDOG_FLAG] = 1'b1;
		end
		if (serial_rx_done_in) begin
			state_next.serial_control_reg[BIT_SERIAL_RX] = 1'b1;
		end
		if (serial_tx_done_in) begin
			state_next.serial_control_reg[BIT_SERIAL_TX] = 1'b1;
		end
		if (timer2_overflow_in) begin
			state_next.timer2_flags_reg[BIT_TIMER2_OVERFLOW] = 1'b1;
		end
		if (timer2_capture_reload_in) begin
			state_next.timer2_flags_reg[BIT_TIMER2_CAPTURE] = 1'b1;
		end
		state_next.dma_flags_reg[5:0] =
			state_next.dma_flags_reg[5:0] | dma_event_in;
		state_next.debug_flags_reg[1:0] =
			state_next.debug_flags_reg[1:0] | hw_breakpoint_in;
		if (test_port_event_in) begin
			state_next.debug_flags_reg[2] = 1'b1;
		end
		if (sw_breakpoint_in) begin
			state_next.debug_flags_reg[3] = 1'b1;
		end

		// register read, data in the next cycle
		if (reg_read_in) begin
			case (reg_addr_in)
				ADDR_TIMER_CONTROL: state_next.rdata =
					state_reg.timer_control_reg;
				ADDR_WATCHDOG_CONTROL: state_next.rdata =
					state_reg.watchdog_control_reg;
				ADDR_BASIC_ENABLE: state_next.rdata =
					state_reg.basic_enable_reg;
				ADDR_EXTENDED_ENABLE: state_next.rdata =
					state_reg.extended_enable_reg;
				ADDR_BASIC_PRIORITY: state_next.rdata =
					state_reg.basic_priority_reg;
				ADDR_EXTENDED_PRIORITY: state_next.rdata =
					state_reg.extended_priority_reg;
				ADDR_SERIAL_CONTROL: state_next.rdata =
					state_reg.serial_control_reg;
				ADDR_TIMER2_FLAGS: state_next.rdata =
					state_reg.timer2_flags_reg;
				ADDR_DMA_FLAGS: state_next.rdata = state_reg.dma_flags_reg;
				ADDR_DEBUG_FLAGS: state_next.rdata =
					state_reg.debug_flags_reg;
				ADDR_IN_SERVICE: state_next.rdata =
					{5'h00, state_reg.in_service};
				default: state_next.rdata = RESET_VALUE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata_out = state_reg.rdata;
	assign call_out = state_reg.call;
	assign call_vector_out = state_reg.vector;
	assign call_level_out = state_reg.level;
	assign call_busy_out = state_reg.busy != 5'h00;
	assign in_service_out = state_reg.in_service;
	assign machine_phase_out = state_reg.phase;

endmodule

`default_nettype wire

// ---- tb/tlic_core_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module tlic_core_chk (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic last_mcycle_in,
	input wire logic enable_write_in,
	input wire logic return_from_irq_in,
	input wire logic call_out,
	input wire logic [tlic_pkg::VEC_W-1:0] call_vector_out,
	input wire logic [1:0] call_level_out,
	input wire logic call_busy_out,
	input wire logic [2:0] in_service_out,
	input wire logic [1:0] machine_phase_out
);
	import tlic_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	// ----------------------------------------------------------------
	// call timing
	// ----------------------------------------------------------------
	AST_CALL_ONE: assert property (call_out |=> !call_out)
		else $error("call pulse too long");
	AST_POLL_PHASE: assert property (
		call_out |-> $past(machine_phase_out) == PHASE_TWO)
		else $error("call not after phase two");
	AST_CALL_COND: assert property (call_out |->
		$past(last_mcycle_in) && !$past(enable_write_in)
		&& !$past(return_from_irq_in))
		else $error("call while conditions unmet");
	AST_BUSY_SPAN: assert property (call_out |->
		call_busy_out ##15 call_busy_out ##1 !call_busy_out)
		else $error("busy span wrong");
	AST_BUSY_START: assert property (
		$rose(call_busy_out) |-> call_out)
		else $error("busy without call");
	AST_NO_BUSY_CALL: assert property (
		call_out |-> !$past(call_busy_out))
		else $error("call during busy");
	// ----------------------------------------------------------------
	// levels
	// ----------------------------------------------------------------
	AST_TOP_VECTOR: assert property (call_out |->
		((call_level_out == LEVEL_TOP) == (call_vector_out == 16'h0033)))
		else $error("top level and vector disagree");
	AST_NO_PREEMPT: assert property (call_out |->
		($past(in_service_out) >> call_level_out) == 3'h0)
		else $error("call at busy or lower level");
	AST_INSVC_SET: assert property (call_out |->
		in_service_out == ($past(in_service_out) | (3'h1 << call_level_out)))
		else $error("in-service not set by call");
	AST_RETURN_FROM_IRQ_TOP: assert property (
		return_from_irq_in && in_service_out[2] |=>
		in_service_out == {1'b0, $past(in_service_out[1:0])})
		else $error("return did not end top level");
	cover property (call_out && call_level_out == LEVEL_LOW);
	cover property (call_out && call_level_out == LEVEL_HIGH);
	cover property (call_out && call_level_out == LEVEL_TOP);
endmodule
bind tlic_core tlic_core_chk i_chk (.mclk_in(mclk_in), .rstn_in(rstn_in),
	.last_mcycle_in(last_mcycle_in), .enable_write_in(enable_write_in),
	.return_from_irq_in(return_from_irq_in), .call_out(call_out),
	.call_vector_out(call_vector_out), .call_level_out(call_level_out),
	.call_busy_out(call_busy_out), .in_service_out(in_service_out),
	.machine_phase_out(machine_phase_out));
`default_nettype wire

// ---- tb/tlic_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [1:0] phase_in,
	input wire logic busy_in,
	input wire logic slow_in,
	input wire logic wr_en_in,
	input wire logic return_from_irq_req_in,
	output logic last_mcycle_out,
	output logic enable_write_out,
	output logic return_from_irq_out
);
	import tlic_pkg::*;
	logic pend_reg;
	// ----------------------------------------------------------------
	// instruction stream
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			last_mcycle_out <= 1'b1;
			enable_write_out <= 1'b0;
			return_from_irq_out <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			// one or two machine cycles per instruction
			if (phase_in == PHASE_FOUR) begin
				last_mcycle_out <= !slow_in || !last_mcycle_out;
			end
			enable_write_out <= wr_en_in;
			return_from_irq_out <= 1'b0;
			pend_reg <= pend_reg || return_from_irq_req_in;
			// return only at an instruction end
			if ((pend_reg || return_from_irq_req_in) && !busy_in && last_mcycle_out
				&& !return_from_irq_out) begin
				return_from_irq_out <= 1'b1;
				pend_reg <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/three_level_interrupt_controller_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module three_level_interrupt_controller_tb_top;
	import tlic_pkg::*;
	logic clk, rstn, wr_s, rd_s, ext0, ext1, slow, wren, return_from_irq_req;
	logic last, enw, return_from_irq, call, busy;
	logic [7:0] addr, wdata, rdata;
	logic [17:0] ev;
	logic [15:0] vec, seed;
	logic [1:0] lvl, phase;
	logic [2:0] insvc;
	int n_mismatch = 0;
	int total_checks = 0;
	localparam logic [7:0] FA [7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h06, 8'h07};
	localparam logic [7:0] FB [7] = '{8'h10, 8'h02, 8'h20, 8'h08, 8'h80,
		8'h01, 8'h80};
	localparam logic [7:0] CA [12] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'h06, 8'h07, 8'h08, 8'h09, 8'h09, 8'h09, 8'h01};
	localparam logic [7:0] CV [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h0C, 8'h08, 8'h00, 8'h00};
	tlic_core i_dut (.mclk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.reg_rdata_out(rdata), .ext_irq_in_0(ext0), .ext_irq_in_1(ext1),
		.top_priority_irq_in(ev[17]), .timer0_overflow_in(ev[0]),
		.timer1_overflow_in(ev[1]), .timer2_overflow_in(ev[2]),
		.timer2_capture_reload_in(ev[3]), .serial_rx_done_in(ev[4]),
		.serial_tx_done_in(ev[5]), .dma_event_in(ev[11:6]),
		.hw_breakpoint_in(ev[13:12]), .test_port_event_in(ev[14]),
		.sw_breakpoint_in(ev[15]), .watchdog_timeout_in(ev[16]),
		.last_mcycle_in(last), .enable_write_in(enw),
		.return_from_irq_in(return_from_irq), .call_out(call), .call_vector_out(vec),
		.call_level_out(lvl), .call_busy_out(busy), .in_service_out(insvc),
		.machine_phase_out(phase));
	tlic_core_model i_core (.mclk_in(clk), .rstn_in(rstn), .phase_in(phase),
		.busy_in(busy), .slow_in(slow), .wr_en_in(wren),
		.return_from_irq_req_in(return_from_irq_req), .last_mcycle_out(last),
		.enable_write_out(enw), .return_from_irq_out(return_from_irq));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [7:0] exp_reg(input logic [7:0] a,
		input logic [7:0] d);
		case (a)
			ADDR_BASIC_ENABLE: return d & MASK_BASIC_ENABLE;
			ADDR_EXTENDED_ENABLE: return d & MASK_EXTENDED_ENABLE;
			ADDR_BASIC_PRIORITY: return d & MASK_BASIC_PRIORITY;
			default: return d & MASK_EXTENDED_PRIORITY;
		endcase
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic pulse(input logic [17:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 18'h00000;
	endtask
	task automatic wait_call(input logic [15:0] v, input logic [1:0] l);
		int n;
		n = 0;
		#1;
		while (call !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		chk({15'h0, call}, 16'h0001);
		chk(vec, v);
		chk({14'h0, lvl}, {14'h0, l});
	endtask
	task automatic no_call(input int n);
		int c;
		c = 0;
		repeat (n) begin
			@(posedge clk);
			#1 if (call !== 1'b0) c++;
		end
		chk(16'(c), 16'h0000);
	endtask
	task automatic do_return_from_irq();
		int n;
		n = 0;
		@(posedge clk);
		return_from_irq_req <= 1'b1;
		@(posedge clk);
		return_from_irq_req <= 1'b0;
		#1;
		while (return_from_irq !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		@(posedge clk);
		#1;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	always #5 clk = ~clk;
	initial begin
		#100us;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		logic [7:0] d;
		int s;
		{clk, rstn, wr_s, rd_s, ext0, ext1, slow, wren, return_from_irq_req} = '0;
		addr = 8'h00;
		wdata = 8'h00;
		ev = 18'h00000;
		seed = 16'hB2AF;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 12; a++) begin
			rd(8'(a), d);
			chk({8'h00, d}, {8'h00, RESET_VALUE});
		end
		for (int a = 2; a < 6; a++) begin
			seed = lfsr(seed);
			wr(8'(a), seed[7:0]);
			rd(8'(a), d);
			chk({8'h00, d}, {8'h00, exp_reg(8'(a), seed[7:0])});
			wr(8'(a), 8'h00);
		end
		wr(ADDR_IN_SERVICE, 8'hFF);
		rd(ADDR_IN_SERVICE, d);
		chk({8'h00, d}, 16'h0000);
		wr(ADDR_TIMER_CONTROL, 8'h05);
		wr(ADDR_EXTENDED_ENABLE, 8'h1F);
		wr(ADDR_BASIC_ENABLE, 8'h3F);
		@(posedge clk) ext0 <= 1'b1;
		@(posedge clk) ext1 <= 1'b1;
		pulse(18'h1FFFF);
		repeat (8) @(posedge clk);
		wr(ADDR_BASIC_ENABLE, 8'hBF);
		for (int k = 1; k < NUM_SRC; k++) begin
			seed = lfsr(seed);
			@(posedge clk) slow <= seed[0];
			wait_call(VECTORS[k], LEVEL_LOW);
			wr(CA[k], CV[k]);
			do_return_from_irq();
		end
		no_call(24);
		rd(ADDR_TIMER_CONTROL, d);
		chk({8'h00, d}, 16'h0005);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		wait_call(16'h0003, LEVEL_LOW);
		rd(ADDR_TIMER_CONTROL, d);
		chk({8'h00, d}, 16'h000A);
		@(posedge clk) ext0 <= 1'b0;
		@(posedge clk) ext1 <= 1'b0;
		repeat (8) @(posedge clk);
		do_return_from_irq();
		no_call(24);
		@(posedge clk) wren <= 1'b1;
		pulse(18'h00004);
		no_call(24);
		wr(ADDR_TIMER2_FLAGS, 8'h00);
		@(posedge clk) wren <= 1'b0;
		no_call(24);
		seed = lfsr(seed);
		s = 1 + int'(seed[7:0]) % 6;
		wr(ADDR_TIMER_CONTROL, 8'h05);
		wr(ADDR_EXTENDED_ENABLE, 8'h3F);
		wr(ADDR_BASIC_PRIORITY, 8'(1 << (s - 1)));
		pulse(18'h10000);
		wait_call(16'h0063, LEVEL_LOW);
		rd(ADDR_WATCHDOG_CONTROL, d);
		chk({8'h00, d}, 16'h0008);
		wr(FA[s], FB[s] | ((FA[s] == 8'h00) ? 8'h05 : 8'h00));
		wait_call(VECTORS[s], LEVEL_HIGH);
		chk({13'h0, insvc}, 16'h0003);
		wr(ADDR_BASIC_ENABLE, 8'h3F);
		pulse(18'h20000);
		wait_call(16'h0033, LEVEL_TOP);
		chk({13'h0, insvc}, 16'h0007);
		wr(ADDR_WATCHDOG_CONTROL, 8'h08);
		do_return_from_irq();
		chk({13'h0, insvc}, 16'h0003);
		wr(FA[s], (FA[s] == 8'h00) ? 8'h05 : 8'h00);
		do_return_from_irq();
		chk({13'h0, insvc}, 16'h0001);
		do_return_from_irq();
		chk({13'h0, insvc}, 16'h0000);
		no_call(24);
		wr(ADDR_EXTENDED_PRIORITY, 8'h10);
		wr(ADDR_BASIC_ENABLE, 8'hBF);
		wait_call(16'h0063, LEVEL_HIGH);
		wr(ADDR_WATCHDOG_CONTROL, 8'h00);
		do_return_from_irq();
		no_call(24);
		print_verdict();
	end
endmodule
`default_nettype wire
